/* File: rtl/cfg_hdr_pkg.sv */
`default_nettype none
package cfg_hdr_pkg;
  localparam int NUM_FUNCTIONS = 2;
  // Configuration offsets are byte addresses inside the 256-byte header
  localparam logic [7:0] OFS_PART_IDENTIFIER = 8'h02;
  localparam logic [7:0] OFS_BUS_COMMAND_CONTROL = 8'h04;
  // Command field positions
  localparam int BIT_IO_SPACE_ENABLE = 0;
  localparam int BIT_MEM_SPACE_ENABLE = 1;
  localparam int BIT_INITIATOR_ENABLE = 2;
  localparam int BIT_SPECIAL_CYCLE = 3;
  localparam int BIT_WRITE_INVALIDATE_ENABLE = 4;
  localparam int BIT_PALETTE_SNOOP = 5;
  localparam int BIT_PARITY_RESPONSE_ENABLE = 6;
  localparam int BIT_STEPPING = 7;
  localparam int BIT_SYSTEM_ERROR_DRIVE_ENABLE = 8;
  localparam int BIT_BACK_TO_BACK_ENABLE = 9;
  localparam int LSB_RESERVED_BITS = 10;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // Only bits 8, 6, 5, 2, 1, 0 hold state; the rest read as zero
  localparam logic [15:0] CMD_WRITABLE_MASK = 16'h0167;
  // Arbitrary neutral part code, not the value of any real product
  localparam logic [15:0] PART_CODE_DEFAULT = 16'h5a3c;
endpackage : cfg_hdr_pkg
`default_nettype wire

/* File: rtl/cmd_if.sv */
`default_nettype none
interface cmd_if;
  logic wr;
  logic [1:0] be;
  logic [15:0] wdata;
  logic [15:0] value;
  modport bank (output wr, output be, output wdata, input value);
  modport slice (input wr, input be, input wdata, output value);
endinterface : cmd_if
`default_nettype wire

/* File: rtl/cmd_reg_slice.sv */
`default_nettype none
module cmd_reg_slice
(
  input wire logic clk_sys,
  input wire logic rst_n,
  cmd_if.slice port
);
  // ----------------------------------------
  // One function's command register
  // ----------------------------------------
  logic [15:0] stored;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stored <= cfg_hdr_pkg::CMD_RESET;
    end
    else if (port.wr)
    begin
      for (int b = 0; b < 2; b++)
      begin
        if (port.be[b])
        begin
          // Hardwired and reserved bits never take a written value
          stored[8*b +: 8] <= port.wdata[8*b +: 8]
                              & cfg_hdr_pkg::CMD_WRITABLE_MASK[8*b +: 8];
        end
      end
    end
  end

  assign port.value = stored;
endmodule : cmd_reg_slice
`default_nettype wire

/* File: rtl/pci_cfg_devid_command.sv */
`default_nettype none
module pci_cfg_devid_command
#(
  // Arbitrary neutral part code
  parameter logic [15:0] PART_CODE = cfg_hdr_pkg::PART_CODE_DEFAULT
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cfg_valid,
  input wire logic cfg_write,
  input wire logic cfg_func,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_byte_en,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_done,
  output logic [31:0] cfg_rdata,
  input wire logic [1:0] io_decode_hit,
  input wire logic [1:0] mem_decode_hit,
  input wire logic [1:0] master_want,
  input wire logic special_cycle_seen,
  input wire logic addr_parity_error,
  input wire logic data_parity_error,
  output logic [1:0] io_claim,
  output logic [1:0] mem_claim,
  output logic [1:0] bus_request,
  output logic [1:0] palette_snoop_enable,
  output logic special_cycle_claim,
  output logic back_to_back_issue,
  output logic write_invalidate_issue,
  output logic serr_o,
  output logic serr_oe,
  output logic perr_o,
  output logic perr_oe
);
  localparam int NF = cfg_hdr_pkg::NUM_FUNCTIONS;
  localparam int CMD_LANE = int'(cfg_hdr_pkg::OFS_BUS_COMMAND_CONTROL[1:0]);
  localparam int PART_LANE = int'(cfg_hdr_pkg::OFS_PART_IDENTIFIER[1:0]);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Function select is one bit wide and every per-function port is two bits
  if (NF != 2)
  begin : g_bad_functions
    $error("Function select serves exactly two functions");
  end

  // Sixteen-bit registers must sit on a half-dword boundary of the byte lanes
  if (CMD_LANE != 0 && CMD_LANE != 2)
  begin : g_bad_cmd_lane
    $error("Command register must start on byte lane 0 or 2");
  end

  if (PART_LANE != 0 && PART_LANE != 2)
  begin : g_bad_part_lane
    $error("Part identifier must start on byte lane 0 or 2");
  end

  // The read mux picks one register per dword and never merges two
  if (cfg_hdr_pkg::OFS_PART_IDENTIFIER[7:2] == cfg_hdr_pkg::OFS_BUS_COMMAND_CONTROL[7:2])
  begin : g_bad_layout
    $error("Part identifier and command register must lie in different dwords");
  end

  // ----------------------------------------
  // Address decode helpers
  // ----------------------------------------
  function automatic logic same_dword(input logic [7:0] a, input logic [7:0] ofs);
    same_dword = (a[7:2] == ofs[7:2]);
  endfunction

  function automatic logic [31:0] place16(input logic [15:0] v, input logic [7:0] ofs);
    place16 = ofs[1] ? {v, 16'h0000} : {16'h0000, v};
  endfunction

  // One command bit of both functions, gathered as a two-bit vector
  function automatic logic [1:0] cmd_column(input logic [15:0] w0, input logic [15:0] w1,
                                            input int pos);
    cmd_column = {w1[pos], w0[pos]};
  endfunction

  // ----------------------------------------
  // Per-function command registers
  // ----------------------------------------
  cmd_if cmd_bus [NF] ();
  logic [15:0] cmd_value [NF];

  // Writes to the part identifier or to unmapped dwords reach no register
  logic cmd_dword_hit;
  logic part_dword_hit;
  logic cmd_write_hit;

  assign cmd_dword_hit = same_dword(cfg_addr, cfg_hdr_pkg::OFS_BUS_COMMAND_CONTROL);
  assign part_dword_hit = same_dword(cfg_addr, cfg_hdr_pkg::OFS_PART_IDENTIFIER);
  assign cmd_write_hit = cfg_valid && cfg_write && cmd_dword_hit;

  for (genvar f = 0; f < NF; f++)
  begin : g_func
    // Only the addressed function's register sees the strobe
    assign cmd_bus[f].wr = cmd_write_hit && (cfg_func == 1'(f));
    assign cmd_bus[f].be = cfg_byte_en[CMD_LANE +: 2];
    assign cmd_bus[f].wdata = cfg_wdata[8*CMD_LANE +: 16];
    assign cmd_value[f] = cmd_bus[f].value;

    cmd_reg_slice u_slice
    (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .port(cmd_bus[f].slice)
    );
  end

  // ----------------------------------------
  // Configuration read path
  // ----------------------------------------
  logic [15:0] sel_cmd;
  logic [31:0] next_rdata;

  always_comb
  begin
    sel_cmd = cmd_value[cfg_func];
    next_rdata = 32'h0000_0000;
    // Vendor and status halves lie outside this block and read zero here
    if (part_dword_hit)
    begin
      next_rdata = place16(PART_CODE, cfg_hdr_pkg::OFS_PART_IDENTIFIER);
    end
    else if (cmd_dword_hit)
    begin
      next_rdata = place16(sel_cmd, cfg_hdr_pkg::OFS_BUS_COMMAND_CONTROL);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_rdata <= 32'h0000_0000;
    end
    else if (cfg_valid && !cfg_write)
    begin
      cfg_rdata <= next_rdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_done <= 1'b0;
    end
    else
    begin
      cfg_done <= cfg_valid;
    end
  end

  // ----------------------------------------
  // Space decode, mastering and snoop gating
  // ----------------------------------------
  logic [1:0] io_en;
  logic [1:0] mem_en;
  logic [1:0] initiator_enable;
  logic [1:0] snoop_bits;
  logic [1:0] sys_err_bits;
  logic [1:0] par_resp_bits;

  assign io_en = cmd_column(cmd_value[0], cmd_value[1],
                            cfg_hdr_pkg::BIT_IO_SPACE_ENABLE);
  assign mem_en = cmd_column(cmd_value[0], cmd_value[1],
                             cfg_hdr_pkg::BIT_MEM_SPACE_ENABLE);
  assign initiator_enable = cmd_column(cmd_value[0], cmd_value[1],
                                       cfg_hdr_pkg::BIT_INITIATOR_ENABLE);
  assign snoop_bits = cmd_column(cmd_value[0], cmd_value[1],
                                 cfg_hdr_pkg::BIT_PALETTE_SNOOP);
  assign sys_err_bits = cmd_column(cmd_value[0], cmd_value[1],
                                   cfg_hdr_pkg::BIT_SYSTEM_ERROR_DRIVE_ENABLE);
  assign par_resp_bits = cmd_column(cmd_value[0], cmd_value[1],
                                    cfg_hdr_pkg::BIT_PARITY_RESPONSE_ENABLE);

  // Registered, so a hit and an enable write in one cycle never race
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_claim <= 2'b00;
    end
    else
    begin
      io_claim <= io_decode_hit & io_en;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_claim <= 2'b00;
    end
    else
    begin
      mem_claim <= mem_decode_hit & mem_en;
    end
  end

  // No request leaves a function whose initiator bit is clear
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_request <= 2'b00;
    end
    else
    begin
      bus_request <= master_want & initiator_enable;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      palette_snoop_enable <= 2'b00;
    end
    else
    begin
      palette_snoop_enable <= snoop_bits;
    end
  end

  // Unsupported initiator features are never issued
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      special_cycle_claim <= 1'b0;
    end
    else
    begin
      special_cycle_claim <= special_cycle_seen & 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      back_to_back_issue <= 1'b0;
    end
    else
    begin
      back_to_back_issue <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      write_invalidate_issue <= 1'b0;
    end
    else
    begin
      write_invalidate_issue <= 1'b0;
    end
  end

  // ----------------------------------------
  // Parity error reporting
  // ----------------------------------------
  logic system_error_drive_enable;
  logic parity_response_enable;

  // Wired-OR across functions, so either function can arm reporting
  assign system_error_drive_enable = |sys_err_bits;
  assign parity_response_enable = |par_resp_bits;

  logic addr_error_report;
  logic data_error_report;

  // Address errors need both enables; data errors need parity response only
  assign addr_error_report = addr_parity_error && system_error_drive_enable
                             && parity_response_enable;
  assign data_error_report = data_parity_error && parity_response_enable;

  // Driver is only ever turned on to pull low, one cycle per error
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serr_oe <= 1'b0;
    end
    else
    begin
      serr_oe <= addr_error_report;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serr_o <= 1'b1;
    end
    else
    begin
      serr_o <= !addr_error_report;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      perr_oe <= 1'b0;
    end
    else
    begin
      perr_oe <= data_error_report;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      perr_o <= 1'b1;
    end
    else
    begin
      perr_o <= !data_error_report;
    end
  end
endmodule : pci_cfg_devid_command
`default_nettype wire

/* File: test/cfg_chk.sv */
`default_nettype none
module cfg_chk
#(
  parameter logic [15:0] PART_CODE = 16'h0000
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cfg_valid,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_done,
  input wire logic [31:0] cfg_rdata,
  input wire logic [1:0] io_decode_hit,
  input wire logic [1:0] mem_decode_hit,
  input wire logic [1:0] master_want,
  input wire logic addr_parity_error,
  input wire logic data_parity_error,
  input wire logic [1:0] io_claim,
  input wire logic [1:0] mem_claim,
  input wire logic [1:0] bus_request,
  input wire logic special_cycle_claim,
  input wire logic back_to_back_issue,
  input wire logic write_invalidate_issue,
  input wire logic serr_o,
  input wire logic serr_oe,
  input wire logic perr_o,
  input wire logic perr_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  done_timing_a: assert property (cfg_done == $past(cfg_valid))
    else $error("done timing");
  fixed_zero_a: assert property (!special_cycle_claim && !back_to_back_issue
    && !write_invalidate_issue) else $error("hardwired output set");
  io_claim_a: assert property ((io_claim & ~$past(io_decode_hit)) == 2'h0)
    else $error("io claim without hit");
  mem_claim_a: assert property ((mem_claim & ~$past(mem_decode_hit)) == 2'h0)
    else $error("mem claim without hit");
  bus_request_a: assert property ((bus_request & ~$past(master_want)) == 2'h0)
    else $error("request without want");
  serr_drive_a: assert property (serr_o == !serr_oe && (!serr_oe || $past(addr_parity_error)))
    else $error("serr drive");
  perr_drive_a: assert property (perr_oe |-> !perr_o && $past(data_parity_error))
    else $error("perr drive");
  cmd_zero_a: assert property (cfg_done && !$past(cfg_write)
    && ($past(cfg_addr) & 8'hfc) == 8'h04 |-> (cfg_rdata & 32'hffff_fe98) == 32'h0)
    else $error("command fixed bits");
  part_code_a: assert property (cfg_done && !$past(cfg_write)
    && ($past(cfg_addr) & 8'hfc) == 8'h00 |-> cfg_rdata == {PART_CODE, 16'h0000})
    else $error("part code");
endmodule // cfg_chk
bind pci_cfg_devid_command cfg_chk #(.PART_CODE(PART_CODE)) chk_u
(
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .cfg_valid(cfg_valid),
  .cfg_write(cfg_write),
  .cfg_addr(cfg_addr),
  .cfg_done(cfg_done),
  .cfg_rdata(cfg_rdata),
  .io_decode_hit(io_decode_hit),
  .mem_decode_hit(mem_decode_hit),
  .master_want(master_want),
  .addr_parity_error(addr_parity_error),
  .data_parity_error(data_parity_error),
  .io_claim(io_claim),
  .mem_claim(mem_claim),
  .bus_request(bus_request),
  .special_cycle_claim(special_cycle_claim),
  .back_to_back_issue(back_to_back_issue),
  .write_invalidate_issue(write_invalidate_issue),
  .serr_o(serr_o),
  .serr_oe(serr_oe),
  .perr_o(perr_o),
  .perr_oe(perr_oe)
);
`default_nettype wire

/* File: test/cfg_host.sv */
`default_nettype none
module cfg_host
(
  input wire logic clk_sys,
  output logic cfg_valid,
  output logic cfg_write,
  output logic cfg_func,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_byte_en,
  output logic [31:0] cfg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {cfg_valid, cfg_write, cfg_func, cfg_addr, cfg_byte_en, cfg_wdata} = 47'h0;
  // One function per access; idle lines show inverted data, never stale
  task automatic access(input logic w, input logic f, input logic [7:0] a,
    input logic [3:0] be, input logic [31:0] d);
    @(posedge clk_sys);
    #1;
    {cfg_valid, cfg_write, cfg_func, cfg_addr, cfg_byte_en, cfg_wdata} = {1'b1, w, f, a, be, d};
    @(posedge clk_sys);
    #1;
    {cfg_valid, cfg_write, cfg_func, cfg_addr, cfg_byte_en, cfg_wdata} = {1'b0, !w, !f, ~a, ~be, ~d};
  endtask
endmodule // cfg_host
`default_nettype wire

/* File: test/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Arbitrary part code
  localparam logic [15:0] PART_CODE = 16'h3c5a;
  typedef struct {logic f; logic [3:0] be; logic [15:0] d; logic [15:0] rb;} row_t;
  row_t rows [7] = '{'{0, 4'h3, 16'hffff, 16'h0167}, '{1, 4'h1, 16'hffff, 16'h0067},
    '{1, 4'h2, 16'h0100, 16'h0167}, '{0, 4'h1, 16'h0000, 16'h0100},
    '{0, 4'h0, 16'hffff, 16'h0100}, '{1, 4'h3, 16'h0000, 16'h0000},
    '{1, 4'hc, 16'hffff, 16'h0000}};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_valid, cfg_write, cfg_func, cfg_done;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_byte_en;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [1:0] io_decode_hit = 2'h0, mem_decode_hit = 2'h0, master_want = 2'h0;
  logic special_cycle_seen = 1'b0, addr_parity_error = 1'b0, data_parity_error = 1'b0;
  logic [1:0] io_claim, mem_claim, bus_request, palette_snoop_enable;
  logic special_cycle_claim, back_to_back_issue, write_invalidate_issue;
  logic serr_o, serr_oe, perr_o, perr_oe;
  int miscompares = 0;
  int samples_checked = 0;
  always #50 clk_sys = ~clk_sys;
  pci_cfg_devid_command #(.PART_CODE(PART_CODE)) dut_u
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cfg_valid(cfg_valid),
    .cfg_write(cfg_write),
    .cfg_func(cfg_func),
    .cfg_addr(cfg_addr),
    .cfg_byte_en(cfg_byte_en),
    .cfg_wdata(cfg_wdata),
    .cfg_done(cfg_done),
    .cfg_rdata(cfg_rdata),
    .io_decode_hit(io_decode_hit),
    .mem_decode_hit(mem_decode_hit),
    .master_want(master_want),
    .special_cycle_seen(special_cycle_seen),
    .addr_parity_error(addr_parity_error),
    .data_parity_error(data_parity_error),
    .io_claim(io_claim),
    .mem_claim(mem_claim),
    .bus_request(bus_request),
    .palette_snoop_enable(palette_snoop_enable),
    .special_cycle_claim(special_cycle_claim),
    .back_to_back_issue(back_to_back_issue),
    .write_invalidate_issue(write_invalidate_issue),
    .serr_o(serr_o),
    .serr_oe(serr_oe),
    .perr_o(perr_o),
    .perr_oe(perr_oe)
  );
  cfg_host host_u
  (
    .clk_sys(clk_sys),
    .cfg_valid(cfg_valid),
    .cfg_write(cfg_write),
    .cfg_func(cfg_func),
    .cfg_addr(cfg_addr),
    .cfg_byte_en(cfg_byte_en),
    .cfg_wdata(cfg_wdata)
  );
  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic f, input logic [3:0] be, input logic [31:0] d);
    host_u.access(1'b1, f, 8'h04, be, d);
    compare(32'(cfg_done), 32'h1);
  endtask
  task automatic rd(input logic f, input logic [7:0] a, input logic [31:0] exp);
    host_u.access(1'b0, f, a, 4'hf, 32'h0);
    compare(32'(cfg_done), 32'h1);
    compare(cfg_rdata, exp);
  endtask
  task automatic pulse_err(input logic adr, input logic [3:0] exp);
    @(posedge clk_sys);
    #1;
    addr_parity_error = adr;
    data_parity_error = !adr;
    @(posedge clk_sys);
    #1;
    addr_parity_error = 1'b0;
    data_parity_error = 1'b0;
    compare(32'({serr_oe, serr_o, perr_oe, perr_o}), 32'(exp));
  endtask
  task automatic report_and_stop;
    $display("Compared %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  initial
  begin
    repeat (6) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    rd(1'b0, 8'h04, 32'h0);
    host_u.access(1'b1, 1'b1, 8'h00, 4'hf, 32'hffff_ffff);
    rd(1'b1, 8'h02, {PART_CODE, 16'h0});
    rd(1'b0, 8'h08, 32'h0);
    foreach (rows[i])
    begin
      wr(rows[i].f, rows[i].be, {16'hffff, rows[i].d});
      rd(rows[i].f, 8'h04, {16'h0, rows[i].rb});
    end
    {io_decode_hit, mem_decode_hit, master_want, special_cycle_seen} = 7'h7f;
    @(posedge clk_sys);
    #1;
    compare(32'({io_claim, mem_claim, bus_request, palette_snoop_enable}), 32'h0);
    compare(32'({special_cycle_claim, back_to_back_issue, write_invalidate_issue}), 32'h0);
    wr(1'b0, 4'h3, 32'h0007);
    wr(1'b1, 4'h3, 32'h0060);
    @(posedge clk_sys);
    #1;
    compare(32'({io_claim, mem_claim, bus_request, palette_snoop_enable}), 32'h56);
    pulse_err(1'b1, 4'h5);
    pulse_err(1'b0, 4'h6);
    wr(1'b0, 4'h3, 32'h0107);
    pulse_err(1'b1, 4'h9);
    rd(1'b1, 8'h04, 32'h0060);
    @(posedge clk_sys);
    #1 rst_n = 1'b0;
    @(posedge clk_sys);
    #1 rst_n = 1'b1;
    rd(1'b0, 8'h04, 32'h0);
    compare(32'({io_claim, mem_claim, bus_request, palette_snoop_enable}), 32'h0);
    report_and_stop;
  end
  initial
  begin
    #100000;
    miscompares++;
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
